/* File: hdl/key_matrix_scanner_consts.svh */
// Purpose: Constants for the key matrix scanner.
// Assumes: 40 MHz system clock.
// Notes:   Timing counts are in system clock cycles.
`ifndef KEY_MATRIX_SCANNER_CONSTS_SVH
`define KEY_MATRIX_SCANNER_CONSTS_SVH
`define KMS_NUM_SCAN        8
`define KMS_NUM_RETURN      4
`define KMS_NUM_OTHER_SEG   63
`define KMS_STROBE_LOW_CYC  16
`define KMS_SAMPLE_POINT    12
`define KMS_STROBE_GAP_CYC  4
`define KMS_LOAD_DELAY      2
`define KMS_REQ_LEAD        2
`define KMS_CYCLE_GAP_CYC   64
`define KMS_KEY_RESET       8'h00
`define KMS_KEY_RET_LSB     4
`define KMS_KEY_SCAN_LSB    0
`endif

/* File: hdl/key_matrix_scanner_pkg.sv */
// Purpose: Types for the key matrix scanner.
// Assumes: Constants header is present.
// Notes:   Holds types only.
package key_matrix_scanner_pkg;
	typedef struct packed
	{
		logic [7:0] strobe_drive;
		logic       strobe_active;
		logic       pullup_en;
		logic       other_idle;
		logic       shared_idle;
	} pin_ctrl_t;

	typedef enum logic [4:0]
	{
		ST_IDLE   = 5'b00001,
		ST_LOW    = 5'b00010,
		ST_GAP    = 5'b00100,
		ST_LOAD   = 5'b01000,
		ST_REST   = 5'b10000
	} scan_state_t;
endpackage

/* File: hdl/key_encoder.sv */
// Purpose: Turns a 32-bit key image into the 8-bit key data field.
// Assumes: Key image bit r*8+s is set when return r meets scan s.
// Notes:   Combinational; the caller registers the result.
`timescale 1ns/1ps
`include "key_matrix_scanner_consts.svh"
module key_encoder
(
	input  wire logic [31:0] key_image_in,
	output logic      [7:0]  key_code_out,
	output logic             any_key_out
);
	// A pressed key sets its return bit and its scan code; keys in one scan column
	// roll over cleanly, keys on different columns cannot be encoded uniquely.
	function automatic logic [7:0] encode(input logic [31:0] img);
		logic [3:0] ret;
		logic [2:0] scan;
		ret  = 4'h0;
		scan = 3'h0;
		for (int r = 0; r < 4; r++)
		begin
			for (int s = 0; s < 8; s++)
			begin
				if (img[r*8+s])
				begin
					ret[r] = 1'b1;
					scan   = 3'(s);
				end
			end
		end
		return {ret, 1'b0, scan};
	endfunction

	// Encoding and presence detection.
	assign key_code_out = (key_image_in == 32'h0000_0000) ? `KMS_KEY_RESET : encode(key_image_in);
	assign any_key_out  = |key_image_in;
endmodule

/* File: hdl/key_matrix_scanner.sv */
// Purpose: Scans a 4x8 key matrix over shared segment pins and latches the key code.
// Assumes: Return inputs are asynchronous pins; host read_busy is on sys_clk_in.
// Notes:   Strobes are active low; a pressed key pulls its return line low.
// Function
// RQ1: Scan four return lines against eight scan lines and capture all 32 switches.
// RQ2: Raise the key request output when a pressed key is detected.
// RQ3: Drop the key request output at least 2 clocks before the next scan cycle begins.
// RQ4: Hold an all-zero key register when no key is operated.
// RQ5: Never update the key register while the host is reading it.
// RQ6: Load the key register 2 clocks after a scan cycle ends and hold it until the next starts.
// RQ7: Emit the strobes on the first eight segment pins only between segment drive periods.
// RQ8: Enable return-input pull-ups only inside the keyscan window while scanning is on.
// RQ9: Hold segments nine to seventy-one at the idle level during the keyscan window.
// RQ10: Apply the keyscan on or off mode that the host selects.
// RQ11: With scanning off, stop detection and pull-ups and idle every segment in the window.
// RQ12: Sample the return inputs three quarters into each strobe's low period.
// RQ13: Capture simultaneous presses correctly under roll-over conditions; the code encodes them uniquely only within one scan column.
// RQ14: Present the captured key data as an 8-bit field for the serial interface.
// RQ15: Set only the return and scan bits that identify the pressed switch.
// RQ16: Keep the key request output low through a cycle that finds no pressed key.
`timescale 1ns/1ps
`include "key_matrix_scanner_consts.svh"
module key_matrix_scanner
	import key_matrix_scanner_pkg::*;
#(
	parameter int STROBE_LOW_CYC = `KMS_STROBE_LOW_CYC,
	parameter int SAMPLE_POINT   = `KMS_SAMPLE_POINT,
	parameter int STROBE_GAP_CYC = `KMS_STROBE_GAP_CYC,
	parameter int CYCLE_GAP_CYC  = `KMS_CYCLE_GAP_CYC
)
(
	input  wire logic                                 sys_clk_in,
	input  wire logic                                 reset_in,
	input  wire logic                                 scan_enable_in,
	input  wire logic                                 read_busy_in,
	input  wire logic [3:0]                           return_inputs_in,
	output logic      [7:0]                           key_data_out,
	output logic                                      key_request_out,
	output logic      [7:0]                           scan_strobes_out,
	output logic                                      keyscan_window_out,
	output logic                                      return_pullup_en_out,
	output logic                                      shared_scan_segments_idle_out,
	output logic                                      other_segment_outputs_idle_out
);
	import key_matrix_scanner_pkg::*;

	localparam int CNT_W = 8;

	scan_state_t      state_q;
	scan_state_t      state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [2:0]       col_q;
	logic [2:0]       col_d;
	logic [3:0]       ret_meta_q;
	logic [3:0]       ret_sync_q;
	logic [1:0]       tap_q;
	logic [5:0]       tap_col_q;
	logic [31:0]      image_q;
	logic [31:0]      image_d;
	logic             mode_q;
	logic [7:0]       key_q;
	logic             req_q;
	logic [7:0]       strobes_q;
	logic             window_q;
	logic             pullup_q;
	logic             shared_idle_q;
	logic             other_idle_q;
	pin_ctrl_t        pins_d;
	logic [7:0]       enc_code;
	logic             enc_any;
	logic             sample_tap;
	logic             sample_now;
	logic             low_done;
	logic             gap_done;
	logic             rest_done;
	logic             load_now;
	logic             req_drop;
	logic             in_window;

	// Two flip-flops on the asynchronous return pins; only the second stage is read.
	// The sample tap and its column ride two stages as well, so they meet the pin value they belong to.
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			ret_meta_q <= 4'hf;
			ret_sync_q <= 4'hf;
			tap_q      <= 2'b00;
			tap_col_q  <= 6'h00;
		end
		else
		begin
			ret_meta_q <= return_inputs_in;
			ret_sync_q <= ret_meta_q;
			tap_q      <= {tap_q[0], sample_tap};
			tap_col_q  <= {tap_col_q[2:0], col_q};
		end
	end

	// Counter landmarks inside each phase.
	// The tap marks the clock in which the strobe pin has been low SAMPLE_POINT clocks.
	assign sample_tap = (state_q == ST_LOW) && (cnt_q == CNT_W'(SAMPLE_POINT)) && mode_q; // RQ12
	assign sample_now = tap_q[1];
	assign low_done   = (state_q == ST_LOW) && (cnt_q == CNT_W'(STROBE_LOW_CYC - 1));
	assign gap_done   = (state_q == ST_GAP) && (cnt_q == CNT_W'(STROBE_GAP_CYC - 1));
	assign load_now   = (state_q == ST_LOAD) && (cnt_q == CNT_W'(`KMS_LOAD_DELAY - 1)); // RQ6
	assign rest_done  = (state_q == ST_REST) && (cnt_q == CNT_W'(CYCLE_GAP_CYC - 1));
	// The request falls a fixed lead ahead of the next cycle so the host sees a clean edge.
	assign req_drop   = (state_q == ST_REST) && (cnt_q == CNT_W'(CYCLE_GAP_CYC - 1 - `KMS_REQ_LEAD)); // RQ3
	assign in_window  = (state_q == ST_LOW) || (state_q == ST_GAP);

	// Scan sequencer next state; the mode is latched once per cycle so a mid-cycle change waits.
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q + CNT_W'(1);
		col_d   = col_q;
		case (state_q)
			ST_IDLE:
			begin
				state_d = ST_LOW;
				cnt_d   = '0;
				col_d   = 3'h0;
			end
			ST_LOW:
			begin
				if (low_done)
				begin
					state_d = ST_GAP;
					cnt_d   = '0;
				end
			end
			ST_GAP:
			begin
				if (gap_done)
				begin
					cnt_d = '0;
					if (col_q == 3'h7)
					begin
						state_d = ST_LOAD;
					end
					else
					begin
						state_d = ST_LOW;
						col_d   = col_q + 3'h1; // RQ1
					end
				end
			end
			ST_LOAD:
			begin
				if (load_now)
				begin
					state_d = ST_REST;
					cnt_d   = '0;
				end
			end
			ST_REST:
			begin
				if (rest_done)
				begin
					state_d = ST_IDLE;
					cnt_d   = '0;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
				cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			col_q   <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			col_q   <= col_d;
		end
	end

	// Mode follows the host selection at each cycle start only.
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			mode_q <= 1'b0;
		else if (state_q == ST_IDLE)
			mode_q <= scan_enable_in; // RQ10
	end

	// Key image: cleared at cycle start, each column sampled at its strobe's three-quarter point.
	// Samples from several returns in one column accumulate, which is the roll-over case we support.
	always_comb
	begin
		image_d = image_q;
		if (state_q == ST_IDLE)
			image_d = 32'h0000_0000;
		else if (sample_now && mode_q) // RQ11
		begin
			for (int r = 0; r < `KMS_NUM_RETURN; r++)
			begin
				image_d[r*8 + int'(tap_col_q[5:3])] = ~ret_sync_q[r]; // RQ13
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			image_q <= 32'h0000_0000;
		else
			image_q <= image_d;
	end

	key_encoder u_encoder
	(
		.key_image_in (image_q),
		.key_code_out (enc_code),
		.any_key_out  (enc_any)
	);

	// Key register loads after the cycle ends unless the host is mid-read, then holds.
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			key_q <= `KMS_KEY_RESET; // RQ4
		else if (load_now && !read_busy_in) // RQ5
			key_q <= enc_code; // RQ15
	end

	// Request rises with a found key at load time and falls ahead of the next cycle.
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			req_q <= 1'b0;
		else if (req_drop || state_q == ST_IDLE)
			req_q <= 1'b0; // RQ16
		else if (load_now && enc_any && mode_q)
			req_q <= 1'b1; // RQ2
	end

	// Pin control for the window; strobes only exist between segment drive periods.
	assign pins_d.strobe_active = (state_q == ST_LOW) && mode_q;
	assign pins_d.strobe_drive  = pins_d.strobe_active ? ~(8'h01 << col_q) : 8'hff; // RQ7
	assign pins_d.pullup_en     = in_window && mode_q; // RQ8
	assign pins_d.other_idle    = in_window; // RQ9
	assign pins_d.shared_idle   = in_window && !mode_q; // RQ11

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			strobes_q     <= 8'hff;
			window_q      <= 1'b0;
			pullup_q      <= 1'b0;
			shared_idle_q <= 1'b0;
			other_idle_q  <= 1'b0;
		end
		else
		begin
			strobes_q     <= pins_d.strobe_drive;
			window_q      <= in_window;
			pullup_q      <= pins_d.pullup_en;
			shared_idle_q <= pins_d.shared_idle;
			other_idle_q  <= pins_d.other_idle;
		end
	end

	// Outputs are the registers themselves.
	assign key_data_out                   = key_q; // RQ14
	assign key_request_out                = req_q;
	assign scan_strobes_out               = strobes_q;
	assign keyscan_window_out             = window_q;
	assign return_pullup_en_out           = pullup_q;
	assign shared_scan_segments_idle_out  = shared_idle_q;
	assign other_segment_outputs_idle_out = other_idle_q;

	// Request is low in the last two clocks before a cycle begins.
	a_req_low_lead: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ3
		(state_q == ST_IDLE) |-> !req_q && $past(!req_q))
		else $error("Request still high near cycle start.");

	// A request may only rise at the load step with a key found.
	a_req_rise_cause: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ2
		$rose(req_q) |-> $past(load_now) && $past(enc_any) && $past(mode_q))
		else $error("Request rose without a key.");

	// Found key at load raises the request next edge.
	a_req_on_key: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ2
		(load_now && enc_any && mode_q) |=> req_q)
		else $error("Request missing for a key.");

	// A load that finds no key leaves the request low.
	a_req_no_key: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ16
		(load_now && !enc_any) |=> !req_q)
		else $error("Request raised with no key.");

	// Key register unchanged while the host reads.
	a_key_hold_read: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ5
		read_busy_in |=> $stable(key_q))
		else $error("Key register changed during a read.");

	// Key register only changes right after the load step.
	a_key_load_time: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ6
		!$stable(key_q) |-> $past(load_now))
		else $error("Key register changed outside the load step.");

	// No pull-ups and no strobes while scanning is off.
	a_off_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ11
		(!mode_q && $past(!mode_q)) |-> !pullup_q && (strobes_q == 8'hff))
		else $error("Scan activity with scanning off.");

	// Pull-ups only inside the window.
	a_pullup_window: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ8
		pullup_q |-> window_q)
		else $error("Pull-up outside the keyscan window.");

	// Other segments idle exactly in the window.
	a_other_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ9
		other_idle_q == window_q)
		else $error("Other segments not idle in the window.");

	// Strobes are one-cold and only in the window.
	a_strobe_onehot: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ7
		(strobes_q != 8'hff) |-> window_q && $onehot(~strobes_q))
		else $error("Bad strobe pattern.");

	// A sample carries the pin value from the three-quarter point of a low strobe with pull-ups on.
	a_sample_point: assert property (@(posedge sys_clk_in) disable iff (reset_in) // RQ12
		sample_now |-> $past((state_q == ST_LOW) && (cnt_q == CNT_W'(SAMPLE_POINT))
			&& !strobes_q[col_q] && pullup_q, 2))
		else $error("Sample outside the low period.");
endmodule

/* File: bench/key_switch_matrix_model.sv */
// Purpose: Behavioural 4x8 switch matrix on the return pins of the scanner.
// Assumes: Strobes are active low; a closed switch pulls its return line to the strobe.
// Notes:   Unpulled lines toggle each clock, so a sample outside the window is never a stable value.
`timescale 1ns/1ps
module key_switch_matrix_model
(
	input  wire logic        clk_in,
	input  wire logic [31:0] pressed_in,
	input  wire logic [7:0]  strobes_in,
	input  wire logic        pullup_en_in,
	output logic      [3:0]  returns_out
);
	logic [3:0] float_q = 4'h5;

	// A floating line shows a changing pattern, not the last driven level.
	always @(posedge clk_in)
		float_q <= ~float_q;

	// Return r goes low when any closed switch on it meets a low strobe.
	always_comb
	begin
		for (int r = 0; r < 4; r++)
			returns_out[r] = pullup_en_in ? ~|(~strobes_in & pressed_in[r*8 +: 8]) : float_q[r];
	end
endmodule

/* File: bench/test_key_matrix_scanner.sv */
// Purpose: Self-checking bench for the key matrix scanner.
// Assumes: Short timing parameters; one scan cycle is 91 clocks.
// Notes:   Cycles are tracked by the keyscan window output.
`timescale 1ns/1ps
module test_key_matrix_scanner;
	logic        sys_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        scan_enable_in = 1'b1;
	logic        read_busy_in = 1'b0;
	logic [31:0] pressed = 32'h0000_0000;
	logic [3:0]  return_inputs_in;
	logic [7:0]  key_data_out;
	logic        key_request_out;
	logic [7:0]  scan_strobes_out;
	logic        keyscan_window_out;
	logic        return_pullup_en_out;
	logic        shared_idle;
	logic        other_idle;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;

	key_matrix_scanner #(.STROBE_LOW_CYC(8), .SAMPLE_POINT(6), .STROBE_GAP_CYC(2), .CYCLE_GAP_CYC(8))
	key_matrix_scanner_i
	(
		.sys_clk_in                    (sys_clk_in),
		.reset_in                      (reset_in),
		.scan_enable_in                (scan_enable_in),
		.read_busy_in                  (read_busy_in),
		.return_inputs_in              (return_inputs_in),
		.key_data_out                  (key_data_out),
		.key_request_out               (key_request_out),
		.scan_strobes_out              (scan_strobes_out),
		.keyscan_window_out            (keyscan_window_out),
		.return_pullup_en_out          (return_pullup_en_out),
		.shared_scan_segments_idle_out (shared_idle),
		.other_segment_outputs_idle_out(other_idle)
	);

	key_switch_matrix_model key_switch_matrix_model_i
	(
		.clk_in      (sys_clk_in),
		.pressed_in  (pressed),
		.strobes_in  (scan_strobes_out),
		.pullup_en_in(return_pullup_en_out),
		.returns_out (return_inputs_in)
	);

	// 40 MHz clock.
	initial
	begin
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	// A hang counts as a mismatch; the run needs about 1550 clocks.
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check_data(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_flag(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic tick();
		@(posedge sys_clk_in);
		#1;
	endtask

	// Runs to the next window, checks pins inside it, then stops early in the rest gap.
	task automatic run_cycle();
		while (keyscan_window_out !== 1'b1)
			tick();
		check_flag("req_at_window_start", 1'b0, key_request_out);
		repeat (3) tick();
		check_flag("pullup_in_window", scan_enable_in, return_pullup_en_out);
		check_flag("other_idle_in_window", 1'b1, other_idle);
		check_flag("shared_idle_in_window", ~scan_enable_in, shared_idle);
		if (!scan_enable_in)
			check_data("strobes_off_mode", 8'hff, scan_strobes_out);
		while (keyscan_window_out === 1'b1)
			tick();
		repeat (4) tick();
		check_data("strobes_outside_window", 8'hff, scan_strobes_out);
		check_flag("pullup_outside_window", 1'b0, return_pullup_en_out);
	endtask

	task automatic scen_no_key();
		pressed = 32'h0;
		repeat (2) run_cycle();
		check_data("key_no_press", 8'h00, key_data_out);
		check_flag("req_no_press", 1'b0, key_request_out);
	endtask

	task automatic scen_one_key();
		pressed = 32'h1 << (2*8 + 2);
		repeat (2) run_cycle();
		check_data("key_r2_c2", 8'h42, key_data_out);
		check_flag("req_press", 1'b1, key_request_out);
	endtask

	// A second reset in mid-run must clear the key, the request and the pins within two clocks.
	task automatic scen_reset();
		reset_in = 1'b1;
		repeat (2) tick();
		check_data("key_after_reset", 8'h00, key_data_out);
		check_flag("req_after_reset", 1'b0, key_request_out);
		check_data("strobes_after_reset", 8'hff, scan_strobes_out);
		check_flag("window_after_reset", 1'b0, keyscan_window_out);
		check_flag("pullup_after_reset", 1'b0, return_pullup_en_out);
		reset_in = 1'b0;
	endtask

	task automatic scen_rollover();
		pressed = (32'h1 << 5) | (32'h1 << (3*8 + 5));
		repeat (2) run_cycle();
		check_data("key_same_column", 8'h95, key_data_out);
	endtask

	task automatic scen_read_busy();
		read_busy_in = 1'b1;
		pressed = 32'h1 << (1*8 + 7);
		repeat (2) run_cycle();
		check_data("key_held_busy", 8'h95, key_data_out);
		read_busy_in = 1'b0;
		repeat (2) run_cycle();
		check_data("key_after_busy", 8'h27, key_data_out);
	endtask

	task automatic scen_scan_off();
		scan_enable_in = 1'b0;
		repeat (3) run_cycle();
		check_data("key_scan_off", 8'h00, key_data_out);
		check_flag("req_scan_off", 1'b0, key_request_out);
		scan_enable_in = 1'b1;
		repeat (2) run_cycle();
		check_data("key_scan_on", 8'h27, key_data_out);
	endtask

	// Main sequence.
	initial
	begin
		repeat (2) @(posedge sys_clk_in);
		#1;
		reset_in = 1'b0;
		scen_no_key();
		scen_one_key();
		scen_reset();
		scen_rollover();
		scen_read_busy();
		scen_scan_off();
		scen_no_key();
		report_and_stop();
	end
endmodule
